// ==== dv/fan_monitor_config_regs_tb.sv ====
// Self-checking testbench of the fan monitor configuration register bank.
`timescale 1ns/1ns
module fan_monitor_config_regs_tb
    import fmc_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0]        pstrb;
    logic [7:0]        dutyRequest = 8'h80;
    logic              spinupStart = 1'b0;
    logic              spinupTimeoutDone = 1'b0;
    logic              fanSpeedPulse = 1'b0;
    logic [7:0]        fanDriveOut1, fanDriveOut2, fanDriveOut3;
    logic              monitorRun, lockActive, deviceReady;
    logic              powerReportFlag, busTimeoutOff, supplyScale5v;
    int                num_errors = 0;
    int                n_checks = 0;
    int                cycles = 0;

    always #20 core_clk = ~core_clk;

    fmc_apb_host host (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    fmc_config_regs DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .dutyRequest1(dutyRequest), .dutyRequest2(dutyRequest),
        .dutyRequest3(dutyRequest), .spinupStart(spinupStart),
        .spinupTimeoutDone(spinupTimeoutDone), .fanSpeedPulse1(fanSpeedPulse),
        .fanSpeedPulse2(fanSpeedPulse), .fanSpeedPulse3(fanSpeedPulse),
        .fanDriveOut1(fanDriveOut1), .fanDriveOut2(fanDriveOut2),
        .fanDriveOut3(fanDriveOut3), .monitorRun(monitorRun),
        .lockActive(lockActive), .deviceReady(deviceReady),
        .powerReportFlag(powerReportFlag), .busTimeoutOff(busTimeoutOff),
        .supplyScale5v(supplyScale5v));

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("[ERR] %0t: run timed out", $time);
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        logic        e;
        host.xfer(1'b1, {2'b00, idx, 2'b00}, {24'h0, v}, d, e);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic        e;
        host.xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, d, e);
        chk(d, {24'h0, exp});
        chk({31'h0, e}, 32'h0);
    endtask

    // Register writes need one edge to land and one more to reach the drive outputs.
    task automatic settle();
        repeat (4) @(posedge core_clk);
    endtask

    // Bit 0 raises the spin-up start, bit 1 the timeout, bit 2 the speed pin, for two cycles.
    task automatic pulse(input logic [2:0] sel);
        @(posedge core_clk);
        {fanSpeedPulse, spinupTimeoutDone, spinupStart} <= sel;
        repeat (2) @(posedge core_clk);
        {fanSpeedPulse, spinupTimeoutDone, spinupStart} <= 3'h0;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic t_reset();
        rd_chk(IDX_DUTY1, 8'hff);
        rd_chk(IDX_DUTY2, 8'hff);
        rd_chk(IDX_DUTY3, 8'hff);
        rd_chk(IDX_CONFIG, 8'h01);
        chk({31'h0, deviceReady}, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_ready();
        int n;
        n = 0;
        while (deviceReady !== 1'b1 && n < 3000) begin
            n++;
            @(posedge core_clk);
        end
        chk({31'h0, deviceReady}, 32'h1);
        rd_chk(IDX_CONFIG, 8'h05);
        wr(IDX_CONFIG, 8'h01);
        rd_chk(IDX_CONFIG, 8'h05);
        $display("t_ready done");
    endtask

    task automatic t_ceiling();
        wr(IDX_DUTY1, 8'h40);
        wr(IDX_DUTY2, 8'h20);
        wr(IDX_DUTY3, 8'h90);
        settle();
        chk({8'h0, fanDriveOut1, fanDriveOut2, fanDriveOut3}, 32'h402080);
        wr(IDX_CONFIG, 8'h00);
        settle();
        chk({23'h0, monitorRun, fanDriveOut1}, 32'h080);
        rd_chk(IDX_DUTY1, 8'h40);
        wr(IDX_CONFIG, 8'h01);
        settle();
        chk({24'h0, fanDriveOut1}, 32'h40);
        wr(IDX_CONFIG, 8'h09);
        settle();
        chk({24'h0, fanDriveOut2}, 32'hff);
        wr(IDX_CONFIG, 8'h01);
        $display("t_ceiling done");
    endtask

    task automatic t_spin();
        for (int opt = 0; opt < 2; opt++) begin
            wr(IDX_CONFIG, (opt == 1) ? 8'h21 : 8'h01);
            pulse(3'h1);
            chk({24'h0, fanDriveOut1}, 32'hff);
            pulse(3'h4);
            pulse(3'h4);
            settle();
            chk({24'h0, fanDriveOut1}, (opt == 1) ? 32'hff : 32'h40);
            pulse(3'h2);
            settle();
            chk({24'h0, fanDriveOut1}, 32'h40);
        end
        $display("t_spin done");
    endtask

    task automatic t_lock();
        wr(IDX_CONFIG, 8'hd1);
        settle();
        chk({29'h0, powerReportFlag, busTimeoutOff, supplyScale5v}, 32'h7);
        wr(IDX_CONFIG, 8'hd3);
        settle();
        chk({31'h0, lockActive}, 32'h1);
        wr(IDX_CONFIG, 8'h28);
        rd_chk(IDX_CONFIG, 8'hff);
        chk({31'h0, monitorRun}, 32'h1);
        wr(IDX_DUTY1, 8'h11);
        rd_chk(IDX_DUTY1, 8'h40);
        wr(IDX_CONFIG, 8'h00);
        rd_chk(IDX_CONFIG, 8'hd7);
        $display("t_lock done");
    endtask

    // Unmapped word: the slave flags an error, reads zero and drops the write.
    task automatic t_unmapped();
        logic [31:0] d;
        logic        e;
        host.xfer(1'b0, 12'h104, 32'h0, d, e);
        chk({e, d[30:0]}, 32'h80000000);
        host.xfer(1'b1, 12'h104, 32'h5a, d, e);
        chk({31'h0, e}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        $display("t_unmapped done");
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_ready();
        t_ceiling();
        t_spin();
        t_lock();
        t_unmapped();
        stop_test();
    end
endmodule // fan_monitor_config_regs_tb

// ==== dv/fmc_apb_host.sv ====
// APB host model that plays the firmware side of the register bank.
`timescale 1ns/1ns
module fmc_apb_host
    import fmc_pkg::*;
(
    // Clock.
    input  wire logic              core_clk,
    // APB master side.
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [DATA_W-1:0]      pwdata,
    output logic [3:0]             pstrb,
    input  wire logic              pready,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
    end

    // The request stays put until pready is seen high, so a slow slave is handled too.
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                        input logic [DATA_W-1:0] wdata,
                        output logic [DATA_W-1:0] rdata, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        pstrb <= 4'hf;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // fmc_apb_host

// ==== rtl/fmc_config_regs.sv ====
// Configuration register bank of the fan monitor, reached over APB.
//
// Contract
// - Three read/write duty ceilings, reset to full scale, bound each fan output.
// - Duty ceilings ignore writes once the lock bit is set.
// - Main configuration resets to 0x01, start bit only.
// - Start bit 1 uses programmed limits; 0 uses built-in default limits.
// - Clearing the start bit keeps programmed limits stored for later use.
// - Start bit becomes read-only after the lock bit is written.
// - Lock bit is write-once; lockable registers stay read-only until power-up.
// - Ready bit is read-only and set by the device when settled.
// - Full-speed bit drives all fans full; resets 0; never locked.
// - Power report flag is a lockable read/write bit with no hardware effect.
// - Spin-up option bit holds outputs high for the whole spin-up timeout.
// - Timeout disable bit turns off the bus timeout; it is lockable.
// - Supply scale bit selects 5 V when 1, 3.3 V when 0; lockable.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module fmc_config_regs
    import fmc_pkg::*;
(
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [DATA_W-1:0]      prdata,
    output logic                   pslverr,
    // Duty requests from the control loop.
    input  wire logic [REG_W-1:0]  dutyRequest1,
    input  wire logic [REG_W-1:0]  dutyRequest2,
    input  wire logic [REG_W-1:0]  dutyRequest3,
    // Spin-up sequencing from the fan timer.
    input  wire logic              spinupStart,
    input  wire logic              spinupTimeoutDone,
    // Fan speed pulse pins.
    input  wire logic              fanSpeedPulse1,
    input  wire logic              fanSpeedPulse2,
    input  wire logic              fanSpeedPulse3,
    // Fan drive duties.
    output logic [REG_W-1:0]       fanDriveOut1,
    output logic [REG_W-1:0]       fanDriveOut2,
    output logic [REG_W-1:0]       fanDriveOut3,
    // Configuration to the monitor core.
    output logic                   monitorRun,
    output logic                   lockActive,
    output logic                   deviceReady,
    output logic                   powerReportFlag,
    output logic                   busTimeoutOff,
    output logic                   supplyScale5v
);

    logic [REG_W-1:0] dutyCeil_reg [NUM_FANS];
    logic [REG_W-1:0] effCeil      [NUM_FANS];
    logic [REG_W-1:0] dutyReq      [NUM_FANS];
    logic [REG_W-1:0] fanDrive     [NUM_FANS];
    logic [NUM_FANS-1:0] fanPulse;

    logic [REG_W-1:0] cfg_reg;
    logic [REG_W-1:0] cfg_next;
    logic [REG_W-1:0] cfgWriteMask;
    logic [REG_W-1:0] cfgView;

    logic [7:0]  wordIdx;
    logic        setupPhase;
    logic        wrAccess;
    logic        wrByte0;
    logic        hitDuty [NUM_FANS];
    logic        hitCfg;
    logic        hitAny;
    logic        readySeen;
    logic        firstCycle_reg;

    // Decode.

    assign wordIdx    = fmc_word_index(paddr);
    assign setupPhase = psel && !penable;
    assign wrAccess   = psel && penable && pwrite;
    assign wrByte0    = wrAccess && pstrb[0];

    assign hitDuty[0] = (wordIdx == IDX_DUTY1);
    assign hitDuty[1] = (wordIdx == IDX_DUTY2);
    assign hitDuty[2] = (wordIdx == IDX_DUTY3);
    assign hitCfg     = (wordIdx == IDX_CONFIG);
    assign hitAny     = hitDuty[0] || hitDuty[1] || hitDuty[2] || hitCfg;

    // Zero wait states: read data is captured during setup and stands in access.
    assign pready = 1'b1;

    // Duty ceiling registers.

    generate
        for (genvar i = 0; i < NUM_FANS; i++) begin : g_ceil
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    dutyCeil_reg[i] <= DUTY_CEIL_RST;
                end else if (wrByte0 && hitDuty[i] && !lockActive) begin
                    dutyCeil_reg[i] <= pwdata[REG_W-1:0];
                end
            end

            // The stored value is never touched by the start bit, only bypassed.
            assign effCeil[i] = monitorRun ? dutyCeil_reg[i] : DUTY_CEIL_RST;
        end
    endgenerate

    // Main configuration register.

    always_comb begin
        cfgWriteMask = CFG_WRITABLE_MASK;
        if (lockActive) begin
            cfgWriteMask = CFG_WRITABLE_MASK & ~CFG_LOCKABLE_MASK;
        end
        cfg_next = (cfg_reg & ~cfgWriteMask) | (pwdata[REG_W-1:0] & cfgWriteMask);
        // The lock can only be set; a written zero never releases it.
        cfg_next[CFG_LOCK_BIT] = cfg_reg[CFG_LOCK_BIT] | pwdata[CFG_LOCK_BIT];
        cfg_next[CFG_READY_BIT] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= CFG_RST;
        end else if (wrByte0 && hitCfg) begin
            cfg_reg <= cfg_next;
        end
    end

    assign monitorRun         = cfg_reg[CFG_RUN_BIT];
    assign lockActive         = cfg_reg[CFG_LOCK_BIT];
    assign powerReportFlag    = cfg_reg[CFG_POWER_BIT];
    assign busTimeoutOff      = cfg_reg[CFG_TIMEOUT_BIT];
    assign supplyScale5v      = cfg_reg[CFG_SUPPLY_BIT];

    // Readback merges the device-owned ready flag into bit 2.
    always_comb begin
        cfgView = cfg_reg;
        cfgView[CFG_READY_BIT] = deviceReady;
    end

    // Power-up settling.

    fmc_ready_timer u_ready (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .readyFlag (deviceReady)
    );

    // APB read data and error, registered in the setup phase.

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= '0;
        end else if (setupPhase) begin
            prdata <= '0;
            if (!pwrite) begin
                if (hitCfg) begin
                    prdata[REG_W-1:0] <= cfgView;
                end else if (hitDuty[0]) begin
                    prdata[REG_W-1:0] <= dutyCeil_reg[0];
                end else if (hitDuty[1]) begin
                    prdata[REG_W-1:0] <= dutyCeil_reg[1];
                end else if (hitDuty[2]) begin
                    prdata[REG_W-1:0] <= dutyCeil_reg[2];
                end
            end
        end
    end

    // Locked writes are dropped silently; only a hole in the map errors.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= !hitAny;
        end
    end

    // Fan outputs.

    assign dutyReq[0] = dutyRequest1;
    assign dutyReq[1] = dutyRequest2;
    assign dutyReq[2] = dutyRequest3;
    assign fanPulse   = {fanSpeedPulse3, fanSpeedPulse2, fanSpeedPulse1};

    generate
        for (genvar f = 0; f < NUM_FANS; f++) begin : g_fan
            fmc_fan_drive u_drive (
                .core_clk           (core_clk),
                .rst_b              (rst_b),
                .dutyRequest        (dutyReq[f]),
                .dutyCeiling        (effCeil[f]),
                .allFansMax         (cfg_reg[CFG_MAX_BIT]),
                .spinupEarlyExitOff (cfg_reg[CFG_SPINUP_BIT]),
                .spinupStart        (spinupStart),
                .spinupTimeoutDone  (spinupTimeoutDone),
                .fanSpeedPulse      (fanPulse[f]),
                .fanDrive           (fanDrive[f])
            );
        end
    endgenerate

    assign fanDriveOut1 = fanDrive[0];
    assign fanDriveOut2 = fanDrive[1];
    assign fanDriveOut3 = fanDrive[2];

    // Checks.

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            firstCycle_reg <= 1'b1;
        end else begin
            firstCycle_reg <= 1'b0;
        end
    end

    assign readySeen = cfgView[CFG_READY_BIT];

    sequence s_cfg_write;
        wrByte0 && hitCfg;
    endsequence

    sequence s_duty1_write_open;
        wrByte0 && hitDuty[0] && !lockActive;
    endsequence

    property p_duty_write;
        @(posedge core_clk) disable iff (!rst_b)
            s_duty1_write_open |=> dutyCeil_reg[0] == $past(pwdata[7:0]);
    endproperty
    a_duty_write: assert property (p_duty_write) else $error("duty write lost");

    property p_duty_locked;
        @(posedge core_clk) disable iff (!rst_b)
            lockActive |=> $stable(dutyCeil_reg[0]) && $stable(dutyCeil_reg[1])
                && $stable(dutyCeil_reg[2]);
    endproperty
    a_duty_locked: assert property (p_duty_locked) else $error("locked duty changed");

    property p_cfg_reset;
        @(posedge core_clk) disable iff (!rst_b)
            firstCycle_reg |-> cfg_reg == CFG_RST && !deviceReady;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("bad configuration reset");

    property p_default_limits;
        @(posedge core_clk) disable iff (!rst_b)
            !monitorRun |-> effCeil[1] == DUTY_CEIL_RST;
    endproperty
    a_default_limits: assert property (p_default_limits) else $error("default limit unused");

    property p_limits_kept;
        @(posedge core_clk) disable iff (!rst_b)
            s_cfg_write ##0 !pwdata[CFG_RUN_BIT]
            |=> $stable(dutyCeil_reg[0]) && $stable(dutyCeil_reg[1])
                && $stable(dutyCeil_reg[2]);
    endproperty
    a_limits_kept: assert property (p_limits_kept) else $error("limit not restored");

    property p_start_locked;
        @(posedge core_clk) disable iff (!rst_b)
            lockActive ##0 s_cfg_write |=> monitorRun == $past(monitorRun);
    endproperty
    a_start_locked: assert property (p_start_locked) else $error("start bit changed");

    property p_lock_once;
        @(posedge core_clk) disable iff (!rst_b) lockActive |=> lockActive [*2];
    endproperty
    a_lock_once: assert property (p_lock_once) else $error("lock released");

    property p_ready_readonly;
        @(posedge core_clk) disable iff (!rst_b)
            s_cfg_write |=> cfg_reg[CFG_READY_BIT] == 1'b0 && readySeen == deviceReady;
    endproperty
    a_ready_readonly: assert property (p_ready_readonly) else $error("ready bit written");

    property p_max_unlockable;
        @(posedge core_clk) disable iff (!rst_b)
            s_cfg_write |=> cfg_reg[CFG_MAX_BIT] == $past(pwdata[3]);
    endproperty
    a_max_unlockable: assert property (p_max_unlockable) else $error("full speed not written");

    property p_locked_bits;
        @(posedge core_clk) disable iff (!rst_b)
            lockActive ##0 s_cfg_write
            |=> (cfg_reg & CFG_LOCKABLE_MASK) == ($past(cfg_reg) & CFG_LOCKABLE_MASK)
                && cfg_reg[CFG_SPINUP_BIT] == $past(pwdata[5]);
    endproperty
    a_locked_bits: assert property (p_locked_bits) else $error("locked bit changed");

    property p_unmapped;
        @(posedge core_clk) disable iff (!rst_b)
            setupPhase && !hitAny |=> pslverr && prdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

    property p_duty_read;
        @(posedge core_clk) disable iff (!rst_b)
            setupPhase && !pwrite && hitDuty[0] |=> prdata == {24'h0, $past(dutyCeil_reg[0])};
    endproperty
    a_duty_read: assert property (p_duty_read) else $error("ceiling read wrong");

    property p_cfg_read;
        @(posedge core_clk) disable iff (!rst_b)
            setupPhase && !pwrite && hitCfg |=> prdata == {24'h0, $past(cfgView)};
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("configuration read wrong");

    property p_open_bits;
        @(posedge core_clk) disable iff (!rst_b)
            !lockActive ##0 s_cfg_write
            |=> {supplyScale5v, busTimeoutOff, powerReportFlag}
                == {$past(pwdata[CFG_SUPPLY_BIT]), $past(pwdata[CFG_TIMEOUT_BIT]),
                    $past(pwdata[CFG_POWER_BIT])};
    endproperty
    a_open_bits: assert property (p_open_bits) else $error("bit not written");

    property p_lock_set;
        @(posedge core_clk) disable iff (!rst_b)
            s_cfg_write ##0 pwdata[CFG_LOCK_BIT] |=> lockActive;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not taken");

    // Only a strobed write that hits the configuration word may move it.
    property p_cfg_gate;
        @(posedge core_clk) disable iff (!rst_b)
            !(wrByte0 && hitCfg) |=> $stable(cfg_reg);
    endproperty
    a_cfg_gate: assert property (p_cfg_gate) else $error("configuration changed unasked");

    // Ceilings move only on an open, strobed write to their own word.
    generate
        for (genvar k = 0; k < NUM_FANS; k++) begin : g_ceil_chk
            property p_ceil_hold;
                @(posedge core_clk) disable iff (!rst_b)
                    !(wrByte0 && hitDuty[k] && !lockActive) |=> $stable(dutyCeil_reg[k]);
            endproperty
            a_ceil_hold: assert property (p_ceil_hold) else $error("ceiling moved");
        end
    endgenerate

endmodule // fmc_config_regs

// ==== rtl/fmc_fan_drive.sv ====
// One fan output: duty ceiling, full-speed override and spin-up handling.
`timescale 1ns/1ns
module fmc_fan_drive
    import fmc_pkg::*;
(
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // Control from the register bank.
    input  wire logic [REG_W-1:0] dutyRequest,
    input  wire logic [REG_W-1:0] dutyCeiling,
    input  wire logic             allFansMax,
    input  wire logic             spinupEarlyExitOff,
    input  wire logic             spinupStart,
    input  wire logic             spinupTimeoutDone,
    // Speed pulse pin.
    input  wire logic             fanSpeedPulse,
    // Drive duty.
    output logic [REG_W-1:0]      fanDrive
);

    logic       pulseMeta_reg;
    logic       pulseSync_reg;
    logic       pulseLast_reg;
    logic       spinning_reg;
    logic [1:0] pulseCnt_reg;
    logic       pulseRise;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulseMeta_reg <= 1'b0;
            pulseSync_reg <= 1'b0;
            pulseLast_reg <= 1'b0;
        end else begin
            pulseMeta_reg <= fanSpeedPulse;
            pulseSync_reg <= pulseMeta_reg;
            pulseLast_reg <= pulseSync_reg;
        end
    end

    assign pulseRise = pulseSync_reg && !pulseLast_reg;

    // Early exit after two pulses is suppressed when the option is set.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            spinning_reg <= 1'b0;
            pulseCnt_reg <= 2'h0;
        end else if (spinupStart) begin
            spinning_reg <= 1'b1;
            pulseCnt_reg <= 2'h0;
        end else if (spinning_reg) begin
            if (spinupTimeoutDone
                || (!spinupEarlyExitOff && pulseCnt_reg == SPINUP_PULSES)) begin
                spinning_reg <= 1'b0;
            end else if (pulseRise && pulseCnt_reg != SPINUP_PULSES) begin
                pulseCnt_reg <= pulseCnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fanDrive <= DUTY_CEIL_RST;
        end else if (allFansMax || spinning_reg) begin
            fanDrive <= DUTY_CEIL_RST;
        end else begin
            fanDrive <= (dutyRequest > dutyCeiling) ? dutyCeiling : dutyRequest;
        end
    end

    property p_spin_hold;
        @(posedge core_clk) disable iff (!rst_b)
            spinning_reg && spinupEarlyExitOff && !spinupTimeoutDone |=> spinning_reg;
    endproperty
    a_spin_hold: assert property (p_spin_hold) else $error("spin-up ended early");

    property p_full_speed;
        @(posedge core_clk) disable iff (!rst_b) allFansMax |=> fanDrive == DUTY_CEIL_RST;
    endproperty
    a_full_speed: assert property (p_full_speed) else $error("full speed not driven");

endmodule // fmc_fan_drive

// ==== rtl/fmc_pkg.sv ====
// Shared constants for the fan monitor configuration register bank.
package fmc_pkg;

    // APB geometry.
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned NUM_FANS = 3;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_DUTY1  = 8'h38;
    localparam logic [7:0] IDX_DUTY2  = 8'h39;
    localparam logic [7:0] IDX_DUTY3  = 8'h3a;
    localparam logic [7:0] IDX_CONFIG = 8'h40;

    // Main configuration field positions.
    localparam int unsigned CFG_RUN_BIT     = 0;
    localparam int unsigned CFG_LOCK_BIT    = 1;
    localparam int unsigned CFG_READY_BIT   = 2;
    localparam int unsigned CFG_MAX_BIT     = 3;
    localparam int unsigned CFG_POWER_BIT   = 4;
    localparam int unsigned CFG_SPINUP_BIT  = 5;
    localparam int unsigned CFG_TIMEOUT_BIT = 6;
    localparam int unsigned CFG_SUPPLY_BIT  = 7;

    // Reset values and access masks.
    localparam logic [7:0] DUTY_CEIL_RST     = 8'hff;
    localparam logic [7:0] CFG_RST           = 8'h01;
    localparam logic [7:0] CFG_WRITABLE_MASK = 8'hfb;
    localparam logic [7:0] CFG_LOCKABLE_MASK = 8'hd3;

    // Timing: internal power-up settling before the ready flag rises.
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned READY_TIME_NS = 100000;
    localparam int unsigned READY_CYCLES  =
        (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned READY_CNT_W   = 12;

    // Speed pulses that end a spin-up early.
    localparam logic [1:0] SPINUP_PULSES = 2'h2;

    // Register index carried by a byte address.
    function automatic logic [7:0] fmc_word_index(input logic [ADDR_W-1:0] addr);
        return addr[9:2];
    endfunction

endpackage

// ==== rtl/fmc_ready_timer.sv ====
// Power-up settling counter that raises the device ready flag.
`timescale 1ns/1ns
module fmc_ready_timer
    import fmc_pkg::*;
(
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Status.
    output logic      readyFlag
);

    logic [READY_CNT_W-1:0] settleCnt_reg;

    // The count saturates, so the flag can only ever rise once per power-up.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            settleCnt_reg <= '0;
        end else if (settleCnt_reg != READY_CNT_W'(READY_CYCLES)) begin
            settleCnt_reg <= settleCnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            readyFlag <= 1'b0;
        end else if (settleCnt_reg == READY_CNT_W'(READY_CYCLES)) begin
            readyFlag <= 1'b1;
        end
    end

    property p_ready_sticky;
        @(posedge core_clk) disable iff (!rst_b) readyFlag |=> readyFlag;
    endproperty
    a_ready_sticky: assert property (p_ready_sticky) else $error("ready flag fell");

endmodule // fmc_ready_timer
